// ==== rtl/tw_pkg.sv ====
package tw_pkg;

	// link register selector values
	localparam logic [7:0] TW_SEL_PART_ID = 8'h00;
	localparam logic [7:0] TW_SEL_REVISION = 8'h01;
	localparam logic [7:0] TW_SEL_UNLOCK = 8'h02;
	localparam logic [7:0] TW_SEL_CMD_DATA = 8'hBF;

	// reset values
	localparam logic [7:0] TW_SELECTOR_RESET = 8'h00;
	localparam logic [7:0] TW_UNLOCK_RESET = 8'h00;
	localparam logic [7:0] TW_CMD_DATA_RESET = 8'h00;

	// unlock sequence codes
	localparam logic [7:0] TW_UNLOCK_FIRST = 8'h02;
	localparam logic [7:0] TW_UNLOCK_SECOND = 8'h01;

	// link frame geometry
	localparam int TW_BYTE_BITS = 8;
	localparam logic [3:0] TW_INS_LAST = 4'h1;
	localparam logic [3:0] TW_DATA_LAST = 4'h7;
	localparam logic [3:0] TW_RDATA_DONE = 4'h8;

	// link instruction codes, bit 0 set for writes
	typedef enum logic [1:0] {
		TW_OP_DATA_READ = 2'b00,
		TW_OP_DATA_WRITE = 2'b01,
		TW_OP_SEL_READ = 2'b10,
		TW_OP_SEL_WRITE = 2'b11
	} tw_op_t;

	typedef enum logic [7:0] {
		TW_CMD_DEVICE_ERASE = 8'h03,
		TW_CMD_BLOCK_READ = 8'h06,
		TW_CMD_BLOCK_WRITE = 8'h07,
		TW_CMD_PAGE_ERASE = 8'h08
	} tw_flash_cmd_t;

	typedef enum logic [2:0] {
		TW_L_IDLE = 3'b000,
		TW_L_INS = 3'b001,
		TW_L_DATA = 3'b010,
		TW_L_WAIT = 3'b011,
		TW_L_RDATA = 3'b100,
		TW_L_WEND = 3'b101
	} tw_link_state_t;

	typedef enum logic [1:0] {
		TW_UL_LOCKED = 2'b00,
		TW_UL_FIRST = 2'b01,
		TW_UL_OPEN = 2'b10
	} tw_unlock_state_t;

	typedef enum logic {
		TW_FP_COMMAND = 1'b0,
		TW_FP_OPERAND = 1'b1
	} tw_flash_phase_t;

	function automatic logic tw_op_is_write(input logic [1:0] op);
		return op[0];
	endfunction : tw_op_is_write

	function automatic logic tw_is_flash_cmd(input logic [7:0] code);
		return (code == TW_CMD_DEVICE_ERASE) || (code == TW_CMD_BLOCK_READ) ||
			(code == TW_CMD_BLOCK_WRITE) || (code == TW_CMD_PAGE_ERASE);
	endfunction : tw_is_flash_cmd

endpackage : tw_pkg

// ==== rtl/tw_sync2.sv ====
`timescale 1ns/100ps
module tw_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk) begin
		stage1 <= d;
		q <= stage1;
	end
endmodule : tw_sync2

// ==== rtl/tw_flash_prog_regs.sv ====
`timescale 1ns/100ps
// Summary of operation
// R1 - link is one clock and one data line
// R2 - selector picks target of data transfers
// R3 - selector zero reads fixed part identifier
// R4 - selector one reads read-only revision code
// R5 - unlock needs 0x02 then 0x01 written
// R6 - programming stays enabled until system reset
// R7 - 0xBF carries flash commands, addresses, data
// R8 - decode 0x06 0x07 0x08 0x03 commands
// R9 - link traffic expected while core halted
// R10 - halted core lends pins to link
// R11 - flash commands ignored until unlocked
module tw_flash_prog_regs
	import tw_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] SILICON_REV = 8'h00
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic link_clock_input,
	input wire logic link_data_line_in,
	output logic link_data_line_out,
	output logic link_data_line_oe,
	input wire logic cpu_halted,
	output logic link_pins_owned,
	output logic flash_prog_enabled,
	output logic flash_cmd_valid,
	output logic [7:0] flash_cmd,
	output logic flash_byte_valid,
	output logic [7:0] flash_byte,
	output logic flash_byte_rd,
	input wire logic flash_done,
	input wire logic flash_rdata_valid,
	input wire logic [7:0] flash_rdata
);

	// link clock domain
	logic l_rst_n;
	logic l_owned;
	logic l_ack_sync;
	logic l_ack_seen;
	logic l_req_tgl;
	logic [1:0] l_op;
	logic [7:0] l_wdata;
	logic [7:0] l_rdata;
	logic [3:0] l_cnt;
	tw_link_state_t l_state;

	// core clock domain
	logic c_req_sync;
	logic c_req_seen;
	logic c_ack_tgl;
	logic [7:0] c_rsp_data;
	logic [7:0] selector;
	logic [7:0] unlock_value;
	logic [7:0] cmd_rdata;
	tw_unlock_state_t unlock_state;
	tw_unlock_state_t next_unlock_state;
	tw_flash_phase_t flash_phase;
	tw_flash_phase_t next_flash_phase;

	tw_sync2 #(.W(1)) u_lrst (
		.clk(link_clock_input),
		.d(rst_n),
		.q(l_rst_n)
	);

	tw_sync2 #(.W(1)) u_owned (
		.clk(link_clock_input),
		.d(link_pins_owned),
		.q(l_owned)
	);

	tw_sync2 #(.W(1)) u_ack (
		.clk(link_clock_input),
		.d(c_ack_tgl),
		.q(l_ack_sync)
	);

	tw_sync2 #(.W(1)) u_req (
		.clk(core_clk),
		.d(l_req_tgl),
		.q(c_req_sync)
	);

	// link side decode
	wire l_start = l_owned && link_data_line_in;
	wire l_ack_new = l_ack_sync != l_ack_seen;
	wire l_is_write = tw_op_is_write(l_op);
	wire [3:0] l_cnt_inc = l_cnt + 4'h1;

	// link frame engine: start, op, data, wait, ready, read data
	always_ff @(posedge link_clock_input) begin
		if (!l_rst_n) begin
			l_state <= TW_L_IDLE;
			l_cnt <= 4'h0;
			l_op <= 2'b00;
			l_wdata <= 8'h00;
			l_rdata <= 8'h00;
			l_req_tgl <= 1'b0;
			l_ack_seen <= 1'b0;
			link_data_line_out <= 1'b0;
			link_data_line_oe <= 1'b0;
		end else begin
			case (l_state)
				TW_L_IDLE: begin
					link_data_line_oe <= 1'b0;
					link_data_line_out <= 1'b0;
					l_cnt <= 4'h0;
					if (l_start) begin // R1 R10
						l_state <= TW_L_INS;
					end
				end
				TW_L_INS: begin
					l_op[l_cnt[0]] <= link_data_line_in;
					l_cnt <= l_cnt_inc;
					if (l_cnt == TW_INS_LAST) begin
						if (l_op[0]) begin
							l_state <= TW_L_DATA;
							l_cnt <= 4'h0;
						end else begin
							l_req_tgl <= ~l_req_tgl;
							link_data_line_oe <= 1'b1;
							link_data_line_out <= 1'b0;
							l_state <= TW_L_WAIT;
						end
					end
				end
				TW_L_DATA: begin
					l_wdata <= {link_data_line_in, l_wdata[7:1]};
					l_cnt <= l_cnt_inc;
					if (l_cnt == TW_DATA_LAST) begin
						l_req_tgl <= ~l_req_tgl;
						link_data_line_oe <= 1'b1;
						link_data_line_out <= 1'b0;
						l_state <= TW_L_WAIT;
					end
				end
				TW_L_WAIT: begin
					link_data_line_oe <= 1'b1;
					if (l_ack_new) begin
						l_ack_seen <= l_ack_sync;
						link_data_line_out <= 1'b1;
						l_cnt <= 4'h0;
						l_rdata <= c_rsp_data;
						if (l_is_write) begin
							l_state <= TW_L_WEND;
						end else begin
							l_state <= TW_L_RDATA;
						end
					end else begin
						link_data_line_out <= 1'b0;
					end
				end
				TW_L_RDATA: begin
					l_cnt <= l_cnt_inc;
					l_rdata <= {1'b0, l_rdata[7:1]};
					if (l_cnt == TW_RDATA_DONE) begin
						link_data_line_oe <= 1'b0;
						link_data_line_out <= 1'b0;
						l_state <= TW_L_IDLE;
					end else begin
						link_data_line_out <= l_rdata[0];
					end
				end
				TW_L_WEND: begin
					link_data_line_oe <= 1'b0;
					link_data_line_out <= 1'b0;
					l_state <= TW_L_IDLE;
				end
				default: begin
					link_data_line_oe <= 1'b0;
					link_data_line_out <= 1'b0;
					l_state <= TW_L_IDLE;
				end
			endcase
		end
	end

	// core side decode; l_op and l_wdata are held stable by the handshake
	wire c_fire = c_req_sync != c_req_seen;
	wire c_data_wr = c_fire && (l_op == TW_OP_DATA_WRITE);
	wire c_data_rd = c_fire && (l_op == TW_OP_DATA_READ);
	wire c_sel_wr = c_fire && (l_op == TW_OP_SEL_WRITE);
	wire c_sel_rd = c_fire && (l_op == TW_OP_SEL_READ);
	wire hit_unlock = selector == TW_SEL_UNLOCK;
	wire hit_cmd = selector == TW_SEL_CMD_DATA;
	wire unlock_wr = c_data_wr && hit_unlock;
	wire cmd_wr = c_data_wr && hit_cmd && flash_prog_enabled; // R7 R11
	wire cmd_rd = c_data_rd && hit_cmd && flash_prog_enabled; // R7
	wire code_ok = tw_is_flash_cmd(l_wdata); // R8
	wire new_cmd = cmd_wr && (flash_phase == TW_FP_COMMAND) && code_ok;
	wire new_operand = cmd_wr && (flash_phase == TW_FP_OPERAND);

	// data read mux, selected by the link selector
	wire [7:0] cmd_view = flash_prog_enabled ? cmd_rdata : TW_CMD_DATA_RESET;
	wire [7:0] data_view =
		(selector == TW_SEL_PART_ID) ? PART_ID : // R2 R3
		(selector == TW_SEL_REVISION) ? SILICON_REV : // R4
		hit_unlock ? unlock_value :
		hit_cmd ? cmd_view : 8'h00;
	wire [7:0] next_rsp_data = c_sel_rd ? selector :
		c_data_rd ? data_view : 8'h00;

	// two-code unlock; open state left only by reset
	always_comb begin
		next_unlock_state = unlock_state;
		case (unlock_state)
			TW_UL_LOCKED: begin
				if (unlock_wr && (l_wdata == TW_UNLOCK_FIRST)) begin // R5
					next_unlock_state = TW_UL_FIRST;
				end
			end
			TW_UL_FIRST: begin
				if (unlock_wr) begin
					if (l_wdata == TW_UNLOCK_SECOND) begin // R5
						next_unlock_state = TW_UL_OPEN;
					end else if (l_wdata != TW_UNLOCK_FIRST) begin
						next_unlock_state = TW_UL_LOCKED;
					end
				end
			end
			TW_UL_OPEN: begin
				next_unlock_state = TW_UL_OPEN; // R6
			end
			default: begin
				next_unlock_state = TW_UL_LOCKED;
			end
		endcase
	end

	// command byte first, then operands until the flash reports done
	always_comb begin
		next_flash_phase = flash_phase;
		case (flash_phase)
			TW_FP_COMMAND: begin
				if (new_cmd) begin
					next_flash_phase = TW_FP_OPERAND;
				end
			end
			TW_FP_OPERAND: begin
				if (flash_done) begin
					next_flash_phase = TW_FP_COMMAND;
				end
			end
			default: begin
				next_flash_phase = TW_FP_COMMAND;
			end
		endcase
	end

	// handshake back to the link
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			c_req_seen <= 1'b0;
			c_ack_tgl <= 1'b0;
			c_rsp_data <= 8'h00;
		end else if (c_fire) begin
			c_req_seen <= c_req_sync;
			c_ack_tgl <= ~c_ack_tgl;
			c_rsp_data <= next_rsp_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			selector <= TW_SELECTOR_RESET;
		end else if (c_sel_wr) begin
			selector <= l_wdata; // R2
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			unlock_value <= TW_UNLOCK_RESET;
			unlock_state <= TW_UL_LOCKED;
			flash_prog_enabled <= 1'b0;
		end else begin
			if (unlock_wr) begin
				unlock_value <= l_wdata;
			end
			unlock_state <= next_unlock_state;
			flash_prog_enabled <= next_unlock_state == TW_UL_OPEN; // R5 R6
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flash_phase <= TW_FP_COMMAND;
			flash_cmd_valid <= 1'b0;
			flash_cmd <= TW_CMD_DATA_RESET;
			flash_byte_valid <= 1'b0;
			flash_byte <= TW_CMD_DATA_RESET;
			flash_byte_rd <= 1'b0;
		end else begin
			flash_phase <= next_flash_phase;
			flash_cmd_valid <= new_cmd; // R8 R11
			flash_byte_valid <= new_operand; // R7
			flash_byte_rd <= cmd_rd;
			if (new_cmd) begin
				flash_cmd <= l_wdata;
			end
			if (new_operand) begin
				flash_byte <= l_wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmd_rdata <= TW_CMD_DATA_RESET;
		end else if (flash_rdata_valid) begin
			cmd_rdata <= flash_rdata;
		end
	end

	// pins are lent to the link only while the core is halted
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			link_pins_owned <= 1'b0;
		end else begin
			link_pins_owned <= cpu_halted; // R9 R10
		end
	end

endmodule : tw_flash_prog_regs

// ==== sim/tw_prog_props.sv ====
`timescale 1ns/100ps
module tw_prog_props
	import tw_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic link_clock_input,
	input wire logic link_data_line_out,
	input wire logic link_data_line_oe,
	input wire logic cpu_halted,
	input wire logic link_pins_owned,
	input wire logic flash_prog_enabled,
	input wire logic flash_cmd_valid,
	input wire logic [7:0] flash_cmd,
	input wire logic flash_byte_rd
);
	sequence wait_bit;
		link_data_line_oe && !link_data_line_out;
	endsequence
	reset_clear_a: assert property (@(posedge core_clk)
		!rst_n |=> !flash_prog_enabled && !flash_cmd_valid)
		else $error("outputs not cleared by reset");
	enable_sticky_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) flash_prog_enabled |=> flash_prog_enabled)
		else $error("programming enable dropped");
	cmd_gate_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) flash_cmd_valid |-> flash_prog_enabled)
		else $error("command while locked");
	cmd_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		flash_cmd_valid |-> flash_cmd inside {8'h03, 8'h06, 8'h07, 8'h08})
		else $error("bad command code");
	cmd_hold_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) $changed(flash_cmd) |-> flash_cmd_valid)
		else $error("command changed without pulse");
	read_gate_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) flash_byte_rd |-> flash_prog_enabled)
		else $error("data read pulse while locked");
	owned_follow_a: assert property (@(posedge core_clk)
		disable iff (!rst_n) cpu_halted |=> link_pins_owned)
		else $error("pins not lent while halted");
	owned_gate_a: assert property (@(posedge link_clock_input)
		disable iff (!rst_n) $rose(link_data_line_oe) |-> link_pins_owned)
		else $error("link driven while not owned");
	wait_first_a: assert property (@(posedge link_clock_input)
		disable iff (!rst_n) $rose(link_data_line_oe) |-> wait_bit)
		else $error("answer not opened by wait bit");
endmodule : tw_prog_props
bind tw_flash_prog_regs tw_prog_props u_tw_prog_props(.core_clk, .rst_n,
	.link_clock_input, .link_data_line_out, .link_data_line_oe, .cpu_halted,
	.link_pins_owned, .flash_prog_enabled, .flash_cmd_valid, .flash_cmd,
	.flash_byte_rd);

// ==== sim/tw_prog_model.sv ====
`timescale 1ns/100ps
module tw_prog_model (
	input wire logic link_data_line_out,
	input wire logic link_data_line_oe,
	output logic link_clock_input,
	output logic link_data_line_in
);
	logic drv_en = 1'b1;
	logic drv_val = 1'b0;
	logic last = 1'b0;
	initial link_clock_input = 1'b0;
	// released line shows inverse of last level
	assign link_data_line_in = link_data_line_oe ? link_data_line_out :
		drv_en ? drv_val : ~last;
	always @(posedge link_clock_input) last <= link_data_line_in;
	task automatic step(input logic b, input logic en);
		link_clock_input = 1'b1;
		#1 drv_val = b;
		drv_en = en;
		#5 link_clock_input = 1'b0;
		#6;
	endtask : step
	task automatic idle(input int n);
		drv_en = 1'b1;
		drv_val = 1'b0;
		// line settles half a period before the first edge
		#6;
		repeat (n) step(1'b0, 1'b1);
	endtask : idle
	// clock runs only within frames and idle calls
	task automatic frame(input logic [1:0] op, input logic [7:0] wd,
		output logic [7:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 8'h00;
		drv_en = 1'b1;
		drv_val = 1'b1;
		// start bit stands half a period before its edge
		#6;
		step(op[0], 1'b1);
		step(op[1], 1'b1);
		for (int i = 0; i < 8; i++)
			if (op[0]) step(wd[i], 1'b1);
		step(1'b0, 1'b0);
		for (n = 0; n < 40 && !ok; n++) begin
			ok = link_data_line_oe === 1'b1 && link_data_line_out === 1'b1;
			if (!ok) step(1'b0, 1'b0);
		end
		if (ok) begin
			for (int i = 0; i < 8; i++)
				if (!op[0]) begin
					step(1'b0, 1'b0);
					rd[i] = link_data_line_out;
				end
			step(1'b0, 1'b0);
			ok = link_data_line_oe === 1'b0;
		end
	endtask : frame
endmodule : tw_prog_model

// ==== sim/tw_flash_prog_regs_tb.sv ====
`timescale 1ns/100ps
module tw_flash_prog_regs_tb
	import tw_pkg::*;
;
	localparam logic [7:0] PID = 8'h3C; // arbitrary value
	localparam logic [7:0] CMDS [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cpu_halted = 1'b0;
	logic flash_done = 1'b0;
	logic flash_rdata_valid = 1'b0;
	logic [7:0] flash_rdata = 8'h00;
	logic link_clock_input, link_data_line_in, link_data_line_out;
	logic link_data_line_oe, link_pins_owned, flash_prog_enabled;
	logic flash_cmd_valid, flash_byte_valid, flash_byte_rd, ok;
	logic [7:0] flash_cmd, flash_byte, rd;
	int fail_count = 0;
	int n_tests = 0;
	int ncmd = 0, nbyte = 0, nrd = 0, cyc = 0;
	always #4 core_clk = ~core_clk;
	tw_flash_prog_regs #(.PART_ID(PID), .SILICON_REV(8'h00))
		u_tw_flash_prog_regs(.core_clk, .rst_n, .link_clock_input,
		.link_data_line_in, .link_data_line_out, .link_data_line_oe,
		.cpu_halted, .link_pins_owned, .flash_prog_enabled, .flash_cmd_valid,
		.flash_cmd, .flash_byte_valid, .flash_byte, .flash_byte_rd,
		.flash_done, .flash_rdata_valid, .flash_rdata);
	tw_prog_model u_tw_prog_model(.link_data_line_out, .link_data_line_oe,
		.link_clock_input, .link_data_line_in);
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	always @(posedge core_clk) begin
		cyc++;
		ncmd += (flash_cmd_valid === 1'b1);
		nbyte += (flash_byte_valid === 1'b1);
		nrd += (flash_byte_rd === 1'b1);
		if (cyc > 20000) begin
			fail_count++;
			$display("mismatch at %0t: timeout", $time);
			close_out;
		end
	end
	task check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task xfer(input logic [1:0] op, input logic [7:0] wd);
		u_tw_prog_model.frame(op, wd, rd, ok);
		repeat (2) @(posedge core_clk);
		check({7'h00, ok}, 8'h01);
	endtask : xfer
	task wr(input logic [7:0] sel, input logic [7:0] d);
		xfer(TW_OP_SEL_WRITE, sel);
		xfer(TW_OP_DATA_WRITE, d);
	endtask : wr
	task rdreg(input logic [7:0] sel, input logic [7:0] exp);
		xfer(TW_OP_SEL_WRITE, sel);
		xfer(TW_OP_DATA_READ, 8'h00);
		check(rd, exp);
	endtask : rdreg
	task do_reset;
		rst_n <= 1'b0;
		fork
			repeat (8) @(posedge core_clk);
			u_tw_prog_model.idle(4);
		join
		rst_n <= 1'b1;
		u_tw_prog_model.idle(3);
		check({4'h0, flash_prog_enabled, flash_cmd_valid, flash_byte_valid,
			flash_byte_rd}, 8'h00);
	endtask : do_reset
	task pulse(input logic rdv, input logic [7:0] d);
		@(posedge core_clk);
		flash_rdata <= d;
		flash_rdata_valid <= rdv;
		flash_done <= !rdv;
		@(posedge core_clk);
		flash_rdata_valid <= 1'b0;
		flash_done <= 1'b0;
	endtask : pulse
	initial begin
		do_reset;
		u_tw_prog_model.frame(TW_OP_SEL_READ, 8'h00, rd, ok);
		check({7'h00, ok}, 8'h00);
		$display("test not_owned ended");
		@(posedge core_clk);
		cpu_halted <= 1'b1;
		repeat (3) @(posedge core_clk);
		u_tw_prog_model.idle(3);
		rdreg(TW_SEL_PART_ID, PID);
		wr(TW_SEL_PART_ID, 8'hFF);
		rdreg(TW_SEL_PART_ID, PID);
		rdreg(TW_SEL_REVISION, 8'h00);
		wr(TW_SEL_REVISION, 8'hFF);
		rdreg(TW_SEL_REVISION, 8'h00);
		xfer(TW_OP_SEL_READ, 8'h00);
		check(rd, TW_SEL_REVISION);
		rdreg(8'h40, 8'h00);
		$display("test identity ended");
		wr(TW_SEL_CMD_DATA, 8'h06);
		check(ncmd[7:0], 8'h00);
		rdreg(TW_SEL_CMD_DATA, 8'h00);
		wr(TW_SEL_UNLOCK, 8'h01);
		wr(TW_SEL_UNLOCK, 8'h02);
		wr(TW_SEL_UNLOCK, 8'h05);
		wr(TW_SEL_UNLOCK, 8'h01);
		check({7'h00, flash_prog_enabled}, 8'h00);
		rdreg(TW_SEL_UNLOCK, 8'h01);
		wr(TW_SEL_UNLOCK, 8'h02);
		wr(TW_SEL_UNLOCK, 8'h01);
		check({7'h00, flash_prog_enabled}, 8'h01);
		$display("test unlock ended");
		xfer(TW_OP_SEL_WRITE, TW_SEL_CMD_DATA);
		foreach (CMDS[i]) begin
			xfer(TW_OP_DATA_WRITE, 8'h11);
			xfer(TW_OP_DATA_WRITE, CMDS[i]);
			xfer(TW_OP_DATA_WRITE, 8'hA5 ^ CMDS[i]);
			check(ncmd[7:0], 8'(i + 1));
			check(flash_cmd, CMDS[i]);
			check(flash_byte, 8'hA5 ^ CMDS[i]);
			pulse(1'b0, 8'h00);
		end
		check(nbyte[7:0], 8'h04);
		pulse(1'b1, 8'hC3);
		xfer(TW_OP_DATA_READ, 8'h00);
		check(rd, 8'hC3);
		check(nrd[7:0], 8'h01);
		$display("test commands ended");
		wr(TW_SEL_UNLOCK, 8'h00);
		check({7'h00, flash_prog_enabled}, 8'h01);
		do_reset;
		$display("test sticky ended");
		close_out;
	end
endmodule : tw_flash_prog_regs_tb
